// >>> logic/pscr_cfg_regs.sv
// Load switch protection and buck converter configuration register bank.
`timescale 1ns/1ns
`default_nettype none
`include "pscr_defs.svh"
module pscr_cfg_regs
  import pscr_pkg::*;
#(
  parameter int NUM_SW    = 3,
  parameter int BLANK_CYC = `PSCR_BLANK_CYC
) (
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  input  wire logic [`PSCR_ADDR_W-1:0] reg_addr_i,
  input  wire logic [7:0]              reg_wdata_i,
  output logic [7:0]                   reg_rdata_o,
  input  wire logic                    unlocked_i,
  input  wire logic                    powerfail_out_low_i,
  input  wire logic [NUM_SW-1:0]       sw_enable_i,
  output logic [NUM_SW-1:0]            sw_on_o,
  output logic [NUM_SW-1:0]            sw_discharge_o,
  output logic                         buck_one_pulse_skip_o,
  output logic                         buck_two_pulse_skip_o,
  output pscr_vcode_t                  buck_one_voltage_code_o,
  output pscr_vcode_t                  buck_two_voltage_code_o,
  output pscr_mv_t                     buck_one_mv_o,
  output pscr_mv_t                     buck_two_mv_o,
  output logic                         buck_one_blank_o,
  output logic                         buck_two_blank_o
);
  logic [7:0]        ls_cfg_ff;
  logic [7:0]        buck1_ff;
  logic [7:0]        buck2_ff;
  logic [7:0]        rdata_ff;
  logic              pfo_s1_ff;
  logic              pfo_s2_ff;
  logic [7:0]        nxt_rdata;
  pscr_wsel_t        wsel;
  logic              wr_ls;
  logic              wr_b1;
  logic              wr_b2;
  logic              apply;
  logic [NUM_SW-1:0] pf_off;
  logic [NUM_SW-1:0] dchg_en;

  function automatic pscr_wsel_t decode(input logic [`PSCR_ADDR_W-1:0] a);
    if (a == `PSCR_OFF_LS_CFG) begin
      decode = PSCR_WR_LS;
    end else if (a == `PSCR_OFF_BUCK1) begin
      decode = PSCR_WR_BUCK1;
    end else if (a == `PSCR_OFF_BUCK2) begin
      decode = PSCR_WR_BUCK2;
    end else begin
      decode = PSCR_WR_NONE;
    end
  endfunction

  assign wsel  = decode(reg_addr_i);
  assign wr_ls = reg_wr_i && (wsel == PSCR_WR_LS);
  assign wr_b1 = reg_wr_i && unlocked_i && (wsel == PSCR_WR_BUCK1);
  assign wr_b2 = reg_wr_i && unlocked_i && (wsel == PSCR_WR_BUCK2);
  // The apply strobes are self-clearing, so the apply register holds no state here.
  assign apply = reg_wr_i && unlocked_i && (reg_addr_i == `PSCR_OFF_APPLY)
              && (reg_wdata_i[`PSCR_POS_APPLY] || reg_wdata_i[`PSCR_POS_APPLY_DSBL]);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ls_cfg_ff <= `PSCR_RST_LS_CFG;
      buck1_ff  <= `PSCR_RST_BUCK;
      buck2_ff  <= `PSCR_RST_BUCK;
      rdata_ff  <= 8'h00;
      pfo_s1_ff <= 1'b1;
      pfo_s2_ff <= 1'b1;
    end else begin
      pfo_s1_ff <= powerfail_out_low_i;
      pfo_s2_ff <= pfo_s1_ff;
      rdata_ff  <= nxt_rdata;
      if (wr_ls) begin
        ls_cfg_ff <= reg_wdata_i & `PSCR_LS_CFG_MASK;
      end
      if (wr_b1) begin
        buck1_ff <= reg_wdata_i & `PSCR_BUCK_MASK;
      end
      if (wr_b2) begin
        buck2_ff <= reg_wdata_i & `PSCR_BUCK_MASK;
      end
    end
  end

  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd_i) begin
      case (wsel)
        PSCR_WR_LS:    nxt_rdata = ls_cfg_ff;
        PSCR_WR_BUCK1: nxt_rdata = buck1_ff;
        PSCR_WR_BUCK2: nxt_rdata = buck2_ff;
        default:       nxt_rdata = 8'h00;
      endcase
    end
  end
  assign reg_rdata_o = rdata_ff;

  assign pf_off  = ls_cfg_ff[`PSCR_POS_PF_OFF +: NUM_SW];
  assign dchg_en = ls_cfg_ff[`PSCR_POS_DCHG +: NUM_SW];

  // Switch control follows the stored bits directly, with no apply step.
  genvar g;
  generate
    for (g = 0; g < NUM_SW; g++) begin : g_sw
      assign sw_on_o[g] = sw_enable_i[g] && !(pf_off[g] && !pfo_s2_ff);
      assign sw_discharge_o[g] = dchg_en[g] && !sw_on_o[g];
    end
  endgenerate

  assign buck_one_pulse_skip_o = buck1_ff[`PSCR_POS_SKIP];
  assign buck_two_pulse_skip_o = buck2_ff[`PSCR_POS_SKIP];

  pscr_buck_chan #(.BLANK_CYC(BLANK_CYC)) u_buck_one (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .wr_i      (wr_b1),
    .apply_i   (apply),
    .code_i    (buck1_ff[5:0]),
    .code_o    (buck_one_voltage_code_o),
    .mv_o      (buck_one_mv_o),
    .blank_o   (buck_one_blank_o)
  );

  pscr_buck_chan #(.BLANK_CYC(BLANK_CYC)) u_buck_two (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .wr_i      (wr_b2),
    .apply_i   (apply),
    .code_i    (buck2_ff[5:0]),
    .code_o    (buck_two_voltage_code_o),
    .mv_o      (buck_two_mv_o),
    .blank_o   (buck_two_blank_o)
  );

  property p_ls_reset;
    @(posedge clk_i) $past(sys_rst_i) |-> ls_cfg_ff == `PSCR_RST_LS_CFG;
  endproperty
  a_ls_reset: assert property (p_ls_reset) else $error("switch config reset wrong");

  property p_pf_off;
    @(posedge clk_i) disable iff (sys_rst_i) (pf_off[0] && !pfo_s2_ff) |-> !sw_on_o[0];
  endproperty
  a_pf_off: assert property (p_pf_off) else $error("switch 1 stays on in power fail");

  property p_pf_ignore;
    @(posedge clk_i) disable iff (sys_rst_i) !pf_off[1] |-> sw_on_o[1] == sw_enable_i[1];
  endproperty
  a_pf_ignore: assert property (p_pf_ignore) else $error("switch 2 gated wrongly");

  property p_dchg;
    @(posedge clk_i) disable iff (sys_rst_i)
      sw_discharge_o[2] == (ls_cfg_ff[`PSCR_POS_DCHG + 2] && !sw_on_o[2]);
  endproperty
  a_dchg: assert property (p_dchg) else $error("switch 3 discharge wrong");

  property p_locked;
    @(posedge clk_i) disable iff (sys_rst_i)
      (reg_wr_i && !unlocked_i) |=> $stable(buck1_ff) && $stable(buck2_ff);
  endproperty
  a_locked: assert property (p_locked) else $error("locked buck write took effect");

  property p_blank;
    @(posedge clk_i) disable iff (sys_rst_i) wr_b1 |=> buck_one_blank_o [*8];
  endproperty
  a_blank: assert property (p_blank) else $error("blanking missing after write");

  property p_hold;
    @(posedge clk_i) disable iff (sys_rst_i) !apply |=> $stable(buck_one_voltage_code_o);
  endproperty
  a_hold: assert property (p_hold) else $error("voltage changed without apply");

  property p_apply;
    @(posedge clk_i) disable iff (sys_rst_i)
      apply |=> buck_two_voltage_code_o == $past(buck2_ff[5:0]);
  endproperty
  a_apply: assert property (p_apply) else $error("apply did not load code");

  property p_resv;
    @(posedge clk_i) disable iff (sys_rst_i) !ls_cfg_ff[7] && !ls_cfg_ff[6] && !buck1_ff[6];
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");

  property p_resv2;
    @(posedge clk_i) disable iff (sys_rst_i) !buck2_ff[6];
  endproperty
  a_resv2: assert property (p_resv2) else $error("buck two reserved bit set");

  property p_ls_wr;
    @(posedge clk_i) disable iff (sys_rst_i)
      wr_ls |=> ls_cfg_ff == ($past(reg_wdata_i) & `PSCR_LS_CFG_MASK);
  endproperty
  a_ls_wr: assert property (p_ls_wr) else $error("switch config write lost");

  property p_b1_wr;
    @(posedge clk_i) disable iff (sys_rst_i)
      wr_b1 |=> buck1_ff == ($past(reg_wdata_i) & `PSCR_BUCK_MASK);
  endproperty
  a_b1_wr: assert property (p_b1_wr) else $error("buck one write lost");

  property p_b2_wr;
    @(posedge clk_i) disable iff (sys_rst_i)
      wr_b2 |=> buck2_ff == ($past(reg_wdata_i) & `PSCR_BUCK_MASK);
  endproperty
  a_b2_wr: assert property (p_b2_wr) else $error("buck two write lost");

  property p_rd_ls;
    @(posedge clk_i) disable iff (sys_rst_i)
      (reg_rd_i && wsel == PSCR_WR_LS) |=> reg_rdata_o == $past(ls_cfg_ff);
  endproperty
  a_rd_ls: assert property (p_rd_ls) else $error("switch config read wrong");

  property p_rd_b2;
    @(posedge clk_i) disable iff (sys_rst_i)
      (reg_rd_i && wsel == PSCR_WR_BUCK2) |=> reg_rdata_o == $past(buck2_ff);
  endproperty
  a_rd_b2: assert property (p_rd_b2) else $error("buck two read wrong");

  property p_rd_none;
    @(posedge clk_i) disable iff (sys_rst_i)
      (reg_rd_i && wsel == PSCR_WR_NONE) |=> reg_rdata_o == 8'h00;
  endproperty
  a_rd_none: assert property (p_rd_none) else $error("unmapped read not zero");

  property p_skp_rst;
    @(posedge clk_i)
      $past(sys_rst_i) |-> buck_one_pulse_skip_o && buck_two_pulse_skip_o;
  endproperty
  a_skp_rst: assert property (p_skp_rst) else $error("skip reset not set");

  property p_skp_wr;
    @(posedge clk_i) disable iff (sys_rst_i)
      wr_b1 |=> buck_one_pulse_skip_o == $past(reg_wdata_i[`PSCR_POS_SKIP]);
  endproperty
  a_skp_wr: assert property (p_skp_wr) else $error("skip bit write lost");

  property p_pf_pin;
    @(posedge clk_i) disable iff (sys_rst_i)
      (pf_off[1] && !$past(powerfail_out_low_i, 2) && !$past(sys_rst_i) && !$past(sys_rst_i, 2))
        |-> !sw_on_o[1];
  endproperty
  a_pf_pin: assert property (p_pf_pin) else $error("switch 2 on in power fail");

  property p_pf_clr;
    @(posedge clk_i) disable iff (sys_rst_i)
      $past(powerfail_out_low_i, 2) |-> sw_on_o == sw_enable_i;
  endproperty
  a_pf_clr: assert property (p_pf_clr) else $error("switch gated without fail");

  property p_pf_free;
    @(posedge clk_i) disable iff (sys_rst_i)
      (pf_off == '0) |-> sw_on_o == sw_enable_i;
  endproperty
  a_pf_free: assert property (p_pf_free) else $error("switch gated without bit");

  property p_dchg_on;
    @(posedge clk_i) disable iff (sys_rst_i) (sw_discharge_o & sw_on_o) == '0;
  endproperty
  a_dchg_on: assert property (p_dchg_on) else $error("discharge while on");

  property p_dchg_1;
    @(posedge clk_i) disable iff (sys_rst_i)
      (dchg_en[0] && !sw_on_o[0]) |-> sw_discharge_o[0];
  endproperty
  a_dchg_1: assert property (p_dchg_1) else $error("switch 1 discharge missing");

  property p_lock_vc;
    @(posedge clk_i) disable iff (sys_rst_i)
      (reg_wr_i && !unlocked_i)
        |=> $stable(buck_one_voltage_code_o) && $stable(buck_two_voltage_code_o);
  endproperty
  a_lock_vc: assert property (p_lock_vc) else $error("locked write moved code");

  property p_apply1;
    @(posedge clk_i) disable iff (sys_rst_i)
      apply |=> buck_one_voltage_code_o == $past(buck1_ff[5:0]);
  endproperty
  a_apply1: assert property (p_apply1) else $error("apply missed buck one");

  property p_hold2;
    @(posedge clk_i) disable iff (sys_rst_i) !apply |=> $stable(buck_two_voltage_code_o);
  endproperty
  a_hold2: assert property (p_hold2) else $error("buck two code moved");

  property p_mv_rst;
    @(posedge clk_i) $past(sys_rst_i)
      |-> buck_one_mv_o == 11'(`PSCR_MV_BASE) && buck_two_mv_o == 11'(`PSCR_MV_BASE);
  endproperty
  a_mv_rst: assert property (p_mv_rst) else $error("reset voltage wrong");

  property p_blank2;
    @(posedge clk_i) disable iff (sys_rst_i) wr_b2 |=> buck_two_blank_o [*8];
  endproperty
  a_blank2: assert property (p_blank2) else $error("buck two blank missing");
endmodule
`default_nettype wire

// >>> common/pscr_defs.svh
// Register offsets, field positions, reset values and timing counts of the configuration bank.
`ifndef PSCR_DEFS_SVH
`define PSCR_DEFS_SVH
`define PSCR_ADDR_W          8
`define PSCR_OFF_LS_CFG      8'h15
`define PSCR_OFF_BUCK1       8'h16
`define PSCR_OFF_BUCK2       8'h17
`define PSCR_OFF_APPLY       8'h1a
`define PSCR_RST_LS_CFG      8'h00
`define PSCR_RST_BUCK        8'h80
`define PSCR_LS_CFG_MASK     8'h3f
`define PSCR_BUCK_MASK       8'hbf
`define PSCR_POS_PF_OFF      3
`define PSCR_POS_DCHG        0
`define PSCR_POS_SKIP        7
`define PSCR_POS_APPLY       0
`define PSCR_POS_APPLY_DSBL  1
`define PSCR_BLANK_US        5000
`define PSCR_CLK_KHZ         25000
`define PSCR_BLANK_CYC       ((`PSCR_BLANK_US * `PSCR_CLK_KHZ) / 1000)
`define PSCR_CODE_KNEE       6'h32
`define PSCR_MV_BASE         850
`define PSCR_MV_KNEE         1350
`define PSCR_MV_FINE         10
`define PSCR_MV_COARSE       25
`endif

// >>> common/pscr_pkg.sv
// Types shared by the configuration bank files.
package pscr_pkg;
  typedef logic [5:0]  pscr_vcode_t;
  typedef logic [10:0] pscr_mv_t;
  typedef enum logic [1:0] {PSCR_WR_NONE, PSCR_WR_LS, PSCR_WR_BUCK1, PSCR_WR_BUCK2} pscr_wsel_t;
endpackage

// >>> logic/pscr_buck_chan.sv
// One buck converter channel: applied code, millivolt value and supervision blanking.
`timescale 1ns/1ns
`default_nettype none
`include "pscr_defs.svh"
module pscr_buck_chan
  import pscr_pkg::*;
#(
  parameter int BLANK_CYC = `PSCR_BLANK_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        wr_i,
  input  wire logic        apply_i,
  input  wire pscr_vcode_t code_i,
  output pscr_vcode_t      code_o,
  output pscr_mv_t         mv_o,
  output logic             blank_o
);
  localparam int CW = $clog2(BLANK_CYC + 1);

  pscr_vcode_t code_ff;
  pscr_mv_t    mv_ff;
  logic [CW-1:0] blank_ff;
  logic [CW-1:0] nxt_blank;
  pscr_mv_t    nxt_mv;

  function automatic pscr_mv_t code_to_mv(input pscr_vcode_t c);
    pscr_mv_t lo;
    pscr_mv_t hi;
    lo = pscr_mv_t'(`PSCR_MV_BASE) + pscr_mv_t'(c) * pscr_mv_t'(`PSCR_MV_FINE);
    hi = pscr_mv_t'(`PSCR_MV_KNEE)
       + pscr_mv_t'(c - `PSCR_CODE_KNEE) * pscr_mv_t'(`PSCR_MV_COARSE);
    code_to_mv = (c <= `PSCR_CODE_KNEE) ? lo : hi;
  endfunction

  assign nxt_mv    = code_to_mv(code_i);
  assign nxt_blank = wr_i ? CW'(BLANK_CYC)
                   : (blank_ff != '0) ? blank_ff - CW'(1) : blank_ff;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      code_ff  <= 6'h00;
      mv_ff    <= 11'(`PSCR_MV_BASE);
      blank_ff <= '0;
    end else begin
      blank_ff <= nxt_blank;
      if (apply_i) begin
        code_ff <= code_i;
        mv_ff   <= nxt_mv;
      end
    end
  end

  assign code_o  = code_ff;
  assign mv_o    = mv_ff;
  assign blank_o = (blank_ff != '0);
endmodule
`default_nettype wire

// >>> test/pscr_cfg_regs_test.sv
// Self-checking bench for the load switch and buck converter configuration bank.
`timescale 1ns/1ns
`default_nettype none
`include "pscr_defs.svh"
module pscr_cfg_regs_test
  import pscr_pkg::*;
;
  localparam int BLANK = 20;
  logic        clk_i               = 1'b0;
  logic        sys_rst_i           = 1'b1;
  logic        reg_wr_i            = 1'b0;
  logic        reg_rd_i            = 1'b0;
  logic [7:0]  reg_addr_i          = 8'h00;
  logic [7:0]  reg_wdata_i         = 8'h00;
  logic        unlocked_i          = 1'b0;
  logic        powerfail_out_low_i = 1'b1;
  logic [2:0]  sw_enable_i         = 3'h0;
  logic [7:0]  reg_rdata_o;
  logic [2:0]  sw_on_o;
  logic [2:0]  sw_discharge_o;
  logic        skip1;
  logic        skip2;
  logic        blank1;
  logic        blank2;
  pscr_vcode_t code1;
  pscr_vcode_t code2;
  pscr_mv_t    mv1;
  pscr_mv_t    mv2;
  int          failures    = 0;
  int          check_count = 0;
  int          cycles      = 0;
  int          n;
  logic [31:0] lfsr_ff     = 32'hef2e1a83;
  logic [31:0] v;
  logic [7:0]  d;
  logic [2:0]  on;
  pscr_vcode_t regc [2]    = '{6'h00, 6'h00};
  pscr_vcode_t appc [2]    = '{6'h00, 6'h00};
  pscr_vcode_t corner [5]  = '{6'h00, 6'h31, 6'h32, 6'h33, 6'h3f};

  pscr_cfg_regs #(.NUM_SW(3), .BLANK_CYC(BLANK)) pscr_cfg_regs_i (
    .clk_i                   (clk_i),
    .sys_rst_i               (sys_rst_i),
    .reg_wr_i                (reg_wr_i),
    .reg_rd_i                (reg_rd_i),
    .reg_addr_i              (reg_addr_i),
    .reg_wdata_i             (reg_wdata_i),
    .reg_rdata_o             (reg_rdata_o),
    .unlocked_i              (unlocked_i),
    .powerfail_out_low_i     (powerfail_out_low_i),
    .sw_enable_i             (sw_enable_i),
    .sw_on_o                 (sw_on_o),
    .sw_discharge_o          (sw_discharge_o),
    .buck_one_pulse_skip_o   (skip1),
    .buck_two_pulse_skip_o   (skip2),
    .buck_one_voltage_code_o (code1),
    .buck_two_voltage_code_o (code2),
    .buck_one_mv_o           (mv1),
    .buck_two_mv_o           (mv2),
    .buck_one_blank_o        (blank1),
    .buck_two_blank_o        (blank2)
  );

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  function logic [31:0] rnd();
    lfsr_ff = {lfsr_ff[30:0], lfsr_ff[31] ^ lfsr_ff[21] ^ lfsr_ff[1] ^ lfsr_ff[0]};
    return lfsr_ff;
  endfunction

  function pscr_mv_t exp_mv(input pscr_vcode_t c);
    if (c <= 6'h32) return 11'(850 + 10 * int'(c));
    return 11'(1350 + 25 * (int'(c) - 50));
  endfunction

  task stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // A write strobe lasts exactly one cycle; the register is settled on return.
  task wr(input logic [7:0] a, input logic [7:0] dat);
    @(negedge clk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = dat;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chk("rdata", 11'(exp), 11'(reg_rdata_o));
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      stop_test();
    end
  end

  initial begin
    repeat (3) @(negedge clk_i);
    sys_rst_i = 1'b0;
    rd(8'h15, 8'h00);
    rd(8'h16, 8'h80);
    rd(8'h17, 8'h80);
    rd(8'h20, 8'h00);
    chk("mv2", 11'd850, mv2);
    chk("skip1", 11'(1), 11'(skip1));
    wr(8'h15, 8'hff);
    rd(8'h15, 8'h3f);
    for (int i = 0; i < 12; i++) begin
      v = (i == 0) ? 32'h738 : rnd();
      wr(8'h15, v[7:0]);
      sw_enable_i = v[10:8];
      powerfail_out_low_i = v[11];
      repeat (3) @(negedge clk_i);
      on = sw_enable_i & ~(v[5:3] & {3{~powerfail_out_low_i}});
      chk("sw_on", 11'(on), 11'(sw_on_o));
      chk("discharge", 11'(v[2:0] & ~on), 11'(sw_discharge_o));
    end
    wr(8'h16, 8'h3f);
    rd(8'h16, 8'h80);
    unlocked_i = 1'b1;
    for (int ch = 0; ch < 2; ch++) begin
      for (int i = 0; i < 7; i++) begin
        v = rnd();
        d = {v[7:6], (i < 5) ? corner[i] : v[5:0]};
        wr(8'h16 + 8'(ch), d);
        regc[ch] = d[5:0];
        chk("held code", 11'(appc[ch]), 11'(ch ? code2 : code1));
        n = 0;
        while ((ch ? blank2 : blank1) === 1'b1 && n < 100) begin
          n++;
          @(negedge clk_i);
        end
        chk("blank cycles", 11'(BLANK), 11'(n));
        rd(8'h16 + 8'(ch), d & 8'hbf);
        chk("skip", 11'(d[7]), 11'(ch ? skip2 : skip1));
        wr(8'h1a, v[8] ? 8'h02 : 8'h01);
        appc = regc;
        chk("code1", 11'(appc[0]), 11'(code1));
        chk("code2", 11'(appc[1]), 11'(code2));
        chk("mv1", exp_mv(appc[0]), mv1);
        chk("mv2", exp_mv(appc[1]), mv2);
      end
    end
    wr(8'h16, {2'b10, appc[0] ^ 6'h2a});
    wr(8'h1a, 8'hfc);
    chk("no strobe", 11'(appc[0]), 11'(code1));
    unlocked_i = 1'b0;
    wr(8'h1a, 8'h03);
    chk("locked apply", 11'(appc[0]), 11'(code1));
    @(negedge clk_i);
    sys_rst_i = 1'b1;
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    chk("reset code1", 11'h000, 11'(code1));
    chk("reset mv1", 11'd850, mv1);
    chk("reset blank1", 11'h000, 11'(blank1));
    rd(8'h16, 8'h80);
    stop_test();
  end
endmodule
`default_nettype wire
